// ==== logic/sbk_pkg.sv ====
package sbk_pkg;
    localparam logic [7:0]  ACK_UART     = 8'h86;
    localparam logic [7:0]  ACK_SIO      = 8'h30;
    localparam logic [7:0]  CMD_RAM      = 8'h10;
    localparam logic [7:0]  CMD_ERASE    = 8'h40;
    localparam logic [7:0]  ACK_ER_EN    = 8'h54;
    localparam logic [7:0]  ACK_ER_DONE  = 8'h4f;
    localparam logic [7:0]  ACK_ER_FAIL  = 8'h4c;
    localparam logic [7:0]  ACK_PA_RAM   = 8'h11;
    localparam logic [7:0]  ACK_PA_ERASE = 8'h41;
    localparam logic [7:0]  ERASED       = 8'hff;
    localparam logic [31:0] PW_FLAG_ADDR = 32'h3f81fff0;
    localparam logic [31:0] PW_FIRST     = 32'h3f81fff4;
    localparam logic [31:0] PW_LAST      = 32'h3f81ffff;
    localparam int          PW_LEN       = 12;
    localparam logic [4:0]  PW_BYTE_LO   = 5'h05;
    localparam logic [4:0]  PW_BYTE_HI   = 5'h10;
    localparam logic [4:0]  SUM_BYTE     = 5'h11;
    localparam int          BIT_RXERR    = 3;
    localparam int          BIT_FAIL     = 0;
    localparam logic [3:0]  NIB_OK       = 4'h0;
    localparam logic [3:0]  NIB_FAIL     = 4'h1;
    localparam logic [3:0]  NIB_RXERR    = 4'h8;
    typedef enum logic [2:0] {
        SBK_MODE   = 3'b000,
        SBK_CMD    = 3'b001,
        SBK_DATA   = 3'b010,
        SBK_ERASE  = 3'b011,
        SBK_RUN    = 3'b100,
        SBK_HALT   = 3'b101
    } sbk_state_t;
endpackage : sbk_pkg

// ==== logic/sbk_sum.sv ====
`timescale 1ns/1ps
module sbk_sum (
    input  wire logic       i_ref_clk,  // System clock
    input  wire logic       i_resetn,   // Sync reset, active low
    input  wire logic       i_clear,    // Restart accumulation
    input  wire logic       i_add,      // Accumulate byte
    input  wire logic [7:0] i_byte,     // Byte to add
    output logic      [7:0] o_check     // Two's complement of sum
);
    logic [7:0] sum;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || i_clear) begin
            sum <= 8'h00;
        end else if (i_add) begin
            sum <= sum + i_byte; // [R20]
        end
    end

    assign o_check = 8'h00 - sum; // [R20]
endmodule : sbk_sum

// ==== logic/sbk_ack.sv ====
`timescale 1ns/1ps
// Rules from the document
// [R1] Ack high nibble copies command high nibble
// [R2] Ack bit 3 flags receive error
// [R3] Ack bit 0 flags command, checksum, password fault
// [R4] Ack bits 1 and 2 always zero; mode ack 0x86 and erase acks 0x54, 0x4F, 0x4C have bit 2 set
// [R5] Clocked link: no receive error reporting
// [R6] Mode ack 0x86 async, 0x30 clocked
// [R7] Async without usable baud: halt silently
// [R8] Valid commands echo 0x10 or 0x40
// [R9] Command ack nibble 8 error, 1 undefined
// [R10] Checksum ack nibble 0, 1 or 8
// [R11] Erase acks 0x54, 0x4F, 0x4C
// [R12] Controller rechecks erase after ready plus 200us
// [R13] Flag byte 0xFF means no password
// [R14] Password is twelve stored bytes
// [R15] RAM always checks; erase only if required
// [R16] RAM: uniform non-erased password gives 0x11
// [R17] Bytes 5..16 compared; mismatch is error
// [R18] Erase: uniform password gives 0x41
// [R19] Check regardless of security enable
// [R20] Checksum is negated modulo-256 sum
// [R21] Controller uses the same checksum method
// [R22] Programmers should store a unique password
// [R23] Controller picks mode by first byte
// [R24] Controller waits 5 s for async echo
// [R25] Ack only after byte assembled and checked
module sbk_ack
    import sbk_pkg::*;
#(
    parameter int PW_BYTES = PW_LEN
) (
    input  wire logic                  i_ref_clk,      // 200 MHz system clock
    input  wire logic                  i_resetn,       // Sync reset, active low
    input  wire logic                  i_mode_valid,   // Mode detection finished, pulse
    input  wire logic                  i_mode_sio,     // 1: clocked link chosen
    input  wire logic                  i_baud_ok,      // Async baud can be set
    input  wire logic                  i_rx_valid,     // Received byte, pulse
    input  wire logic [7:0]            i_rx_data,      // Received byte
    input  wire logic                  i_rx_err,       // Framing/overrun on this byte
    input  wire logic [7:0]            i_pw_flag,      // Stored requirement byte
    input  wire logic [8*PW_BYTES-1:0] i_pw_store,     // Stored password, byte 0 low
    input  wire logic                  i_security_on,  // Security enabled (no effect)
    input  wire logic                  i_erase_start,  // Erase enabled, pulse
    input  wire logic                  i_erase_done,   // Erase finished, pulse
    input  wire logic                  i_erase_fail,   // Erase aborted, pulse
    input  wire logic                  i_tx_ready,     // Link can take an ack
    output logic                       o_tx_valid,     // Ack byte presented
    output logic      [7:0]            o_tx_data,      // Ack byte
    output logic                       o_tx_sio,       // Link mode for the ack
    output logic                       o_halted,       // Stopped on bad baud
    output logic                       o_cmd_ram,      // RAM transfer accepted
    output logic                       o_cmd_erase,    // Erase accepted
    output logic                       o_sum_ok,       // Header checksum and password good
    output logic      [7:0]            o_check         // Running checksum value
);
    sbk_state_t state;
    logic [4:0] byte_no;
    logic [3:0] cmd_hi;
    logic       is_erase;
    logic       pw_bad;
    logic       sio;
    logic       rx_err_q;
    logic       pend;
    logic [7:0] next_ack;
    logic       next_send;

    // Receive errors are meaningless on the clocked link
    assign rx_err_q = i_rx_err && !sio; // [R5]

    function automatic logic [7:0] pw_byte(input logic [8*PW_BYTES-1:0] v, input int k);
        pw_byte = v[8*k +: 8];
    endfunction : pw_byte

    // Stored password consists of one repeated byte
    logic pw_uniform;
    always_comb begin
        pw_uniform = 1'b1;
        for (int k = 1; k < PW_BYTES; k++) begin
            if (pw_byte(i_pw_store, k) != pw_byte(i_pw_store, 0)) begin
                pw_uniform = 1'b0;
            end
        end
    end

    logic pw_needed;
    // Security state is deliberately not consulted
    assign pw_needed = !is_erase || (i_pw_flag != ERASED); // [R13] [R15] [R19]

    logic area_err;
    always_comb begin
        if (!is_erase) begin
            area_err = pw_uniform && (pw_byte(i_pw_store, 0) != ERASED); // [R16]
        end else begin
            area_err = pw_needed && pw_uniform; // [R18]
        end
    end

    logic       sum_clear;
    logic       sum_add;
    logic [7:0] check;
    assign sum_clear = (state == SBK_CMD);
    assign sum_add   = i_rx_valid && (state == SBK_DATA) && (byte_no < SUM_BYTE);

    sbk_sum u_sum (
        .i_ref_clk (i_ref_clk),
        .i_resetn  (i_resetn),
        .i_clear   (sum_clear),
        .i_add     (sum_add),
        .i_byte    (i_rx_data),
        .o_check   (check)
    );
    assign o_check = check;

    // Ack content decision; one byte in, at most one ack out
    always_comb begin
        next_ack  = 8'h00;
        next_send = 1'b0;
        if (state == SBK_MODE && i_mode_valid) begin
            next_send = i_mode_sio || i_baud_ok; // [R7]
            next_ack  = i_mode_sio ? ACK_SIO : ACK_UART; // [R6]
        end else if (state == SBK_CMD && i_rx_valid) begin
            next_send = 1'b1; // [R25]
            if (rx_err_q) begin
                next_ack = {i_rx_data[7:4], NIB_RXERR}; // [R9] [R2]
            end else if (i_rx_data == CMD_RAM || i_rx_data == CMD_ERASE) begin
                next_ack = i_rx_data; // [R8]
            end else begin
                next_ack = {i_rx_data[7:4], NIB_FAIL}; // [R9] [R3] [R4]
            end
        end else if (state == SBK_DATA && i_rx_valid && byte_no == SUM_BYTE) begin
            next_send = 1'b1; // [R25]
            if (rx_err_q) begin
                next_ack = {cmd_hi, NIB_RXERR}; // [R10] [R2] [R1]
            end else if (pw_needed && area_err) begin
                next_ack = is_erase ? ACK_PA_ERASE : ACK_PA_RAM; // [R16] [R18]
            end else if ((i_rx_data != check) || (pw_needed && pw_bad)) begin
                next_ack = {cmd_hi, NIB_FAIL}; // [R10] [R3] [R1]
            end else begin
                next_ack = {cmd_hi, NIB_OK}; // [R10] [R4]
            end
        end else if (state == SBK_ERASE) begin
            next_send = i_erase_start || i_erase_done || i_erase_fail;
            if (i_erase_fail) begin
                next_ack = ACK_ER_FAIL; // [R11]
            end else if (i_erase_done) begin
                next_ack = ACK_ER_DONE; // [R11]
            end else begin
                next_ack = ACK_ER_EN; // [R11]
            end
        end
    end

    // Sequencer
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            state   <= SBK_MODE;
            byte_no <= 5'h00;
        end else begin
            case (state)
                SBK_MODE: begin
                    if (i_mode_valid) begin
                        state <= (i_mode_sio || i_baud_ok) ? SBK_CMD : SBK_HALT; // [R7]
                    end
                end
                SBK_CMD: begin
                    if (i_rx_valid && !rx_err_q &&
                        (i_rx_data == CMD_RAM || i_rx_data == CMD_ERASE)) begin
                        state   <= SBK_DATA;
                        byte_no <= 5'h04;
                    end
                end
                SBK_DATA: begin
                    if (i_rx_valid) begin
                        if (byte_no == SUM_BYTE) begin
                            if (next_ack[3:0] != NIB_OK) begin
                                state <= SBK_CMD;
                            end else begin
                                state <= is_erase ? SBK_ERASE : SBK_RUN;
                            end
                        end else begin
                            byte_no <= byte_no + 5'h01;
                        end
                    end
                end
                SBK_ERASE: begin
                    if (i_erase_done || i_erase_fail) begin
                        state <= SBK_CMD;
                    end
                end
                SBK_RUN:  state <= SBK_RUN;
                SBK_HALT: state <= SBK_HALT;
                default:  state <= SBK_MODE;
            endcase
        end
    end

    // Command context and link mode
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            cmd_hi   <= 4'h0;
            is_erase <= 1'b0;
            sio      <= 1'b0;
        end else begin
            if (state == SBK_MODE && i_mode_valid) begin
                sio <= i_mode_sio;
            end
            if (state == SBK_CMD && i_rx_valid) begin
                cmd_hi   <= i_rx_data[7:4]; // [R1]
                is_erase <= (i_rx_data == CMD_ERASE);
            end
        end
    end

    // Password comparison over received bytes 5..16
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || state == SBK_CMD) begin
            pw_bad <= 1'b0;
        end else if (state == SBK_DATA && i_rx_valid &&
                     byte_no >= PW_BYTE_LO && byte_no <= PW_BYTE_HI) begin
            if (i_rx_data != pw_byte(i_pw_store, int'(byte_no - PW_BYTE_LO))) begin
                pw_bad <= 1'b1; // [R17]
            end
        end
    end

    // Ack holding stage; a new ack overwrites the held one at once, even before it has left
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pend      <= 1'b0;
            o_tx_data <= 8'h00;
        end else if (next_send) begin
            pend      <= 1'b1; // [R25]
            o_tx_data <= next_ack;
        end else if (pend && i_tx_ready) begin
            pend <= 1'b0;
        end
    end

    assign o_tx_valid = pend;
    assign o_tx_sio   = sio;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_halted    <= 1'b0;
            o_cmd_ram   <= 1'b0;
            o_cmd_erase <= 1'b0;
            o_sum_ok    <= 1'b0;
        end else begin
            o_halted    <= (state == SBK_HALT);
            o_cmd_ram   <= (state == SBK_DATA || state == SBK_RUN) && !is_erase;
            o_cmd_erase <= (state == SBK_DATA || state == SBK_ERASE) && is_erase;
            o_sum_ok    <= (state == SBK_RUN || state == SBK_ERASE);
        end
    end
endmodule : sbk_ack

// ==== sim/sbk_ack_checker.sv ====
`timescale 1ns/1ps
module sbk_ack_checker
    import sbk_pkg::*;
(
    input wire logic       i_ref_clk,     // Clock
    input wire logic       i_resetn,      // Reset
    input wire logic       i_mode_valid,  // Mode done
    input wire logic       i_mode_sio,    // Clocked link
    input wire logic       i_baud_ok,     // Baud usable
    input wire logic       i_rx_valid,    // Byte in
    input wire logic       i_erase_start, // Erase on
    input wire logic       i_erase_done,  // Erase end
    input wire logic       i_erase_fail,  // Erase abort
    input wire logic       i_tx_ready,    // Ack taken
    input wire logic       o_tx_valid,    // Ack shown
    input wire logic [7:0] o_tx_data,     // Ack byte
    input wire logic       o_tx_sio,      // Ack link
    input wire logic       o_halted,      // Stopped
    input wire logic       o_cmd_ram      // RAM command
);
    logic seen;
    logic evt;
    assign evt = i_rx_valid | i_mode_valid | i_erase_start | i_erase_done | i_erase_fail;
    // Only the first mode pulse after reset is taken
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) seen <= 1'b0;
        else if (i_mode_valid) seen <= 1'b1;
    end
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_mode_uart;
        !seen && i_mode_valid && !i_mode_sio && i_baud_ok |=> o_tx_valid && o_tx_data == ACK_UART;
    endproperty
    a_mode_uart: assert property (p_mode_uart) else $error("async mode ack");
    property p_mode_sio;
        !seen && i_mode_valid && i_mode_sio |=> o_tx_valid && o_tx_data == ACK_SIO;
    endproperty
    a_mode_sio: assert property (p_mode_sio) else $error("clocked mode ack");
    property p_halt;
        !seen && i_mode_valid && !i_mode_sio && !i_baud_ok |=> !o_tx_valid ##1 o_halted;
    endproperty
    a_halt: assert property (p_halt) else $error("no halt on bad baud");
    property p_halt_mute;
        o_halted |-> !o_tx_valid;
    endproperty
    a_halt_mute: assert property (p_halt_mute) else $error("ack while halted");
    property p_bits;
        o_tx_valid && o_cmd_ram |-> o_tx_data[2:1] == 2'b00;
    endproperty
    a_bits: assert property (p_bits) else $error("ack bits 2:1 set");
    property p_sio_noerr;
        o_tx_valid && o_tx_sio |-> !o_tx_data[3];
    endproperty
    a_sio_noerr: assert property (p_sio_noerr) else $error("rx error on clocked");
    property p_stand;
        o_tx_valid && !i_tx_ready && !evt |=> o_tx_valid && $stable(o_tx_data);
    endproperty
    a_stand: assert property (p_stand) else $error("ack dropped early");
    property p_cause;
        $rose(o_tx_valid) |-> $past(evt);
    endproperty
    a_cause: assert property (p_cause) else $error("ack without cause");
endmodule : sbk_ack_checker

bind sbk_ack sbk_ack_checker u_chk (.i_ref_clk, .i_resetn, .i_mode_valid, .i_mode_sio,
    .i_baud_ok, .i_rx_valid, .i_erase_start, .i_erase_done, .i_erase_fail, .i_tx_ready,
    .o_tx_valid, .o_tx_data, .o_tx_sio, .o_halted, .o_cmd_ram);

// ==== sim/sbk_ctl_model.sv ====
`timescale 1ns/1ps
module sbk_ctl_model (
    input  wire logic       i_ref_clk,  // Clock
    input  wire logic       i_slow,     // Stall acks
    input  wire logic       i_tx_valid, // Ack offered
    input  wire logic [7:0] i_tx_data,  // Ack byte
    output logic            o_tx_ready, // Take ack
    output logic      [7:0] o_ack,      // Last ack
    output int              o_acks      // Ack count
);
    int wait_cnt = 0;
    initial o_tx_ready = 1'b0;
    initial o_ack = 8'h00;
    initial o_acks = 0;
    // Ready moves on the falling edge so it is settled at the sampling edge
    always @(negedge i_ref_clk) begin
        if (o_tx_ready) begin
            o_tx_ready = 1'b0;
            wait_cnt = 0;
        end else if (i_tx_valid && wait_cnt >= (i_slow ? 6 : 0)) o_tx_ready = 1'b1;
        else if (i_tx_valid) wait_cnt++;
    end
    always @(posedge i_ref_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            o_ack <= i_tx_data;
            o_acks <= o_acks + 1;
        end
    end
endmodule : sbk_ctl_model

// ==== sim/testbench.sv ====
`timescale 1ns/1ps
module testbench;
    import sbk_pkg::*;
    logic i_ref_clk = 1'b0, i_resetn = 1'b0, i_mode_valid = 1'b0, i_mode_sio = 1'b0;
    logic i_baud_ok = 1'b1, i_rx_valid = 1'b0, i_rx_err = 1'b0, i_security_on = 1'b0;
    logic i_erase_start = 1'b0, i_erase_done = 1'b0, i_erase_fail = 1'b0, slow = 1'b0;
    logic [7:0] i_rx_data = 8'h00, i_pw_flag = 8'hff, o_tx_data, o_check, ack;
    logic [95:0] i_pw_store = 96'h0;
    logic i_tx_ready, o_tx_valid, o_tx_sio, o_halted, o_cmd_ram, o_cmd_erase, o_sum_ok;
    int acks, n0, failures = 0, tests_run = 0;
    always #2.5 i_ref_clk = ~i_ref_clk;
    sbk_ack #(.PW_BYTES(12)) dut_u (.i_ref_clk, .i_resetn, .i_mode_valid, .i_mode_sio,
        .i_baud_ok, .i_rx_valid, .i_rx_data, .i_rx_err, .i_pw_flag, .i_pw_store,
        .i_security_on, .i_erase_start, .i_erase_done, .i_erase_fail, .i_tx_ready,
        .o_tx_valid, .o_tx_data, .o_tx_sio, .o_halted, .o_cmd_ram, .o_cmd_erase,
        .o_sum_ok, .o_check);
    sbk_ctl_model ctl_u (.i_ref_clk, .i_slow(slow), .i_tx_valid(o_tx_valid),
        .i_tx_data(o_tx_data), .o_tx_ready(i_tx_ready), .o_ack(ack), .o_acks(acks));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : end_sim
    task automatic chk(string n, logic [7:0] s, logic [7:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task automatic pulse(ref logic p);
        @(negedge i_ref_clk) p = 1'b1;
        @(negedge i_ref_clk) p = 1'b0;
    endtask : pulse
    task automatic send(logic [7:0] b, logic e);
        @(negedge i_ref_clk);
        i_rx_data = b;
        i_rx_err = e;
        pulse(i_rx_valid);
    endtask : send
    // Bounded wait for the controller to take one more ack
    task automatic get(logic [7:0] e, string n);
        int k;
        k = acks;
        for (int i = 0; i < 40 && acks == k; i++) @(negedge i_ref_clk);
        if (acks == k) begin
            failures++;
            end_sim();
        end else begin
            chk(n, ack, e);
        end
    endtask : get
    task automatic rst(logic s, logic b);
        @(negedge i_ref_clk) i_resetn = 1'b0;
        i_mode_sio = s;
        i_baud_ok = b;
        repeat (4) @(negedge i_ref_clk);
        i_resetn = 1'b1;
        pulse(i_mode_valid);
    endtask : rst
    // Command, one free byte, twelve password bytes, then the checksum byte
    task automatic frame(logic [7:0] c, logic [7:0] x, logic [7:0] o, logic e);
        logic [7:0] s;
        s = 8'h5a;
        send(c, 1'b0);
        get(c, "cmd ack");
        send(8'h5a, 1'b0);
        for (int i = 0; i < 12; i++) begin
            send(i_pw_store[8*i +: 8] ^ x, 1'b0);
            s += i_pw_store[8*i +: 8] ^ x;
        end
        send(8'h00 - s + o, e);
    endtask : frame
    initial begin
        for (int i = 0; i < 12; i++) i_pw_store[8*i +: 8] = 8'h21 + 8'(i);
        rst(1'b0, 1'b1);
        get(ACK_UART, "async mode");
        send(8'h20, 1'b0);
        get(8'h21, "undefined cmd");
        send(8'h70, 1'b1);
        get(8'h78, "cmd rx error");
        frame(CMD_RAM, 8'h00, 8'h01, 1'b0);
        get(8'h11, "bad checksum");
        frame(CMD_RAM, 8'h01, 8'h00, 1'b0);
        get(8'h11, "bad password");
        frame(CMD_RAM, 8'h00, 8'h00, 1'b1);
        get(8'h18, "sum rx error");
        i_security_on = 1'b1;
        slow = 1'b1;
        frame(CMD_RAM, 8'h00, 8'h00, 1'b0);
        get(8'h10, "good ram");
        chk("sum ok", {7'h00, o_sum_ok}, 8'h01);
        // The last byte sent was the controller's own checksum
        chk("checksum", o_check, i_rx_data);
        rst(1'b0, 1'b1);
        get(ACK_UART, "async mode");
        frame(CMD_ERASE, 8'h01, 8'h00, 1'b0);
        get(8'h40, "erase no pw");
        chk("erase cmd", {7'h00, o_cmd_erase}, 8'h01);
        pulse(i_erase_start);
        get(ACK_ER_EN, "erase on");
        pulse(i_erase_done);
        get(ACK_ER_DONE, "erase end");
        // Controller holds off 200 us before it rechecks the erase status
        repeat (40000) @(negedge i_ref_clk);
        chk("erase over", {7'h00, o_cmd_erase}, 8'h00);
        i_pw_flag = 8'h00;
        frame(CMD_ERASE, 8'h00, 8'h00, 1'b0);
        get(8'h40, "erase pw ok");
        pulse(i_erase_fail);
        get(ACK_ER_FAIL, "erase abort");
        i_pw_store = {12{8'h33}};
        frame(CMD_ERASE, 8'h00, 8'h00, 1'b0);
        get(ACK_PA_ERASE, "erase area");
        frame(CMD_RAM, 8'h00, 8'h00, 1'b0);
        get(ACK_PA_RAM, "ram area");
        rst(1'b1, 1'b0);
        get(ACK_SIO, "clocked mode");
        chk("tx link", {7'h00, o_tx_sio}, 8'h01);
        send(8'h10, 1'b1);
        get(8'h10, "clocked no rx err");
        n0 = acks;
        rst(1'b0, 1'b0);
        repeat (30) @(negedge i_ref_clk);
        chk("halted", {7'h00, o_halted}, 8'h01);
        chk("silent", 8'(acks - n0), 8'h00);
        end_sim();
    end
endmodule : testbench
